/* emc_pkg.sv */
/*
  constants, state types and pin groups for the external bus strobe and
  reset-mode control block.
  assumes the system clock is the crystal oscillator itself, one edge per
  oscillator period.
*/
package emc_pkg;

  // machine cycle length in oscillator periods
  localparam int         EMC_OSC_PER_MC_STD = 12;
  localparam int         EMC_OSC_PER_MC_SIX = 6;
  localparam logic [2:0] EMC_HALF_STD       = 3'(EMC_OSC_PER_MC_STD / 2);
  localparam logic [2:0] EMC_HALF_SIX       = 3'(EMC_OSC_PER_MC_SIX / 2);

  // strobe windows inside one half machine cycle, by sub-period
  localparam logic [2:0] EMC_ALE_FIRST_STD   = 3'h1;
  localparam logic [2:0] EMC_ALE_LAST_STD    = 3'h2;
  localparam logic [2:0] EMC_ALE_FIRST_SIX   = 3'h1;
  localparam logic [2:0] EMC_ALE_LAST_SIX    = 3'h1;
  localparam logic [2:0] EMC_FETCH_FIRST_STD = 3'h3;
  localparam logic [2:0] EMC_FETCH_LAST_STD  = 3'h5;
  localparam logic [2:0] EMC_FETCH_FIRST_SIX = 3'h2;
  localparam logic [2:0] EMC_FETCH_LAST_SIX  = 3'h2;
  localparam logic [2:0] EMC_XSTB_FIRST      = 3'h1;

  // reset pin timing in machine cycles, and the expanded RAM page
  localparam logic [4:0] EMC_RESET_MC  = 5'h02;
  localparam logic [4:0] EMC_HOST_MC   = 5'h0a;
  localparam logic [4:0] EMC_HELD_SAT  = 5'h1f;
  localparam logic [7:0] EMC_ERAM_PAGE = 8'h00;

  typedef enum logic [2:0] {
    EMC_ST_RUN  = 3'b001,
    EMC_ST_HELD = 3'b010,
    EMC_ST_HOST = 3'b100
  } emc_state_type;

  // data memory request from the core
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        wide;
    logic [15:0] addr;
  } emc_xreq_type;

  // bus pins driven by the block
  typedef struct packed {
    logic       program_fetch_strobe_n;
    logic       fetch_oe;
    logic       ale;
    logic       ale_oe;
    logic       rd_n;
    logic       wr_n;
    logic [7:0] addr_hi;
    logic       addr_hi_oe;
  } emc_pins_type;

  localparam emc_pins_type EMC_PINS_RST = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 8'h00, 1'b0};

  typedef struct packed {
    logic [2:0] sub;
    logic       half;
    logic       last;
  } emc_tmr_type;

  localparam emc_tmr_type EMC_TMR_RST = '{3'h0, 1'b0, 1'b0};

  typedef struct packed {
    emc_state_type st;
    logic [4:0]    held_mc;
    logic          edge_seen;
    logic          fetch_prev;
    logic          program_pulse_in_n_prev;
    logic          ext_fetch;
    logic          acc_active;
    logic          acc_write;
    logic          acc_ext;
    logic          acc_wide;
    logic [7:0]    acc_hi;
    logic          core_reset;
    logic          host_mode;
    logic          xdone;
    logic          program_pulse_in_n_pulse;
    emc_pins_type  pins;
  } emc_main_type;

  localparam emc_main_type EMC_MAIN_RST = '{EMC_ST_RUN, 5'h00, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0,
                                            1'b0, 1'b0, 8'h00, 1'b0, 1'b0, 1'b0, 1'b0, EMC_PINS_RST};

  // true while s lies in the closed window first..last
  function automatic logic emc_in_win(input logic [2:0] s, input logic [2:0] first,
                                      input logic [2:0] last);
    return (s >= first) && (s <= last);
  endfunction

endpackage

/* emc_mc_timer.sv */
/*
  machine cycle timer: splits each machine cycle into two halves of
  sub-periods and flags the last oscillator period of the cycle.
  assumes one clock edge per oscillator period.
*/
`timescale 1ns/1ps
module emc_mc_timer (
  input  wire logic   clk_i,
  input  wire logic   rst_n_i,
  input  wire logic   six_clk_i,
  output logic [2:0]  sub_o,
  output logic        half_o,
  output logic        last_o
);
  import emc_pkg::*;

  emc_tmr_type t_reg;
  emc_tmr_type t_next;
  logic [2:0]  half_len;

  // sub-period count, half toggle, last period of the cycle
  always_comb begin
    t_next   = t_reg;
    half_len = six_clk_i ? EMC_HALF_SIX : EMC_HALF_STD;
    if (t_reg.sub >= half_len - 3'h1) begin  // [R19]
      t_next.sub  = 3'h0;
      t_next.half = !t_reg.half;
    end else begin
      t_next.sub = t_reg.sub + 3'h1;
    end
    t_next.last = (t_next.sub == half_len - 3'h1) && t_next.half;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      t_reg <= EMC_TMR_RST;
    end else begin
      t_reg <= t_next;
    end
  end

  assign sub_o  = t_reg.sub;
  assign half_o = t_reg.half;
  assign last_o = t_reg.last;

  property p_sub_range;
    @(posedge clk_i) disable iff (!rst_n_i)
    $stable(six_clk_i) && $past(t_reg.sub) < half_len |-> t_reg.sub < half_len;
  endproperty
  a_sub_range: assert property (p_sub_range) else $error("sub-period beyond half length"); // [R19]

endmodule

/* emc_strobe_ctrl.sv */
/*
  external bus strobe and reset-mode control: fetch strobe, address latch
  pulse, data read/write strobes, high address byte, reset pin timing and
  external-host mode entry.
  assumes the clock is the crystal oscillator and all pin inputs are
  already synchronous to it.
*/
// Functional notes
// R1: write strobe low on external data write
// R2: read strobe low on external data read
// R3: fetch strobe high for internal code fetch
// R4: fetch strobe pulses twice per machine cycle
// R5: skip two fetch pulses per data access
// R6: fetch-pin fall in long reset enters host mode
// R7: reset high two machine cycles resets device
// R8: no fetch-pin fall leaves to normal mode
// R9: strap low external fetch, high internal
// R10: boot lockout forces internal execution only
// R11: latch pulse marks every external access
// R12: latch pulse at one sixth oscillator rate
// R13: six-clock mode latch pulse one third rate
// R14: drop one latch pulse per data access
// R15: latch-pulse-off bit stops free-running pulses
// R16: latch pin becomes programming pulse input
// R17: high address byte on external accesses
// R18: expanded RAM access leaves bus idle
// R19: machine cycle twelve or six oscillator periods
`timescale 1ns/1ps
module emc_strobe_ctrl #(
  parameter logic [4:0] RESET_MC      = emc_pkg::EMC_RESET_MC,
  parameter logic [4:0] HOST_ENTRY_MC = emc_pkg::EMC_HOST_MC
) (
  input  wire logic            CLK_SYS_I,
  input  wire logic            RST_N_I,
  input  wire logic            DEV_RESET_I,
  input  wire logic            EXTERNAL_FETCH_STRAP_N_I,
  input  wire logic            BOOT_LOCKOUT_I,
  input  wire logic            SIX_CLOCK_MODE_I,
  input  wire logic            LATCH_PULSE_OFF_I,
  input  wire logic            EXPANDED_RAM_OFF_I,
  input  wire logic [7:0]      FETCH_ADDR_HI_I,
  input  wire emc_pkg::emc_xreq_type XREQ_I,
  input  wire logic            PROGRAM_FETCH_STROBE_N_I,
  input  wire logic            PROGRAM_PULSE_IN_N_I,
  output emc_pkg::emc_pins_type PINS_O,
  output logic                 XBUSY_O,
  output logic                 XDONE_O,
  output logic                 CORE_RESET_O,
  output logic                 HOST_MODE_O,
  output logic                 PROGRAM_PULSE_IN_N_PULSE_O
);
  import emc_pkg::*;

  if (RESET_MC < 5'h01 || HOST_ENTRY_MC < RESET_MC || HOST_ENTRY_MC >= EMC_HELD_SAT) begin : g_chk
    $error("reset machine-cycle counts out of range");
  end

  emc_main_type r_reg;
  emc_main_type r_next;
  logic [2:0]   t_sub;
  logic         t_half;
  logic         t_last;
  logic         ext_fetch;
  logic         ale_win;
  logic         fetch_win;
  logic         ext_data;
  logic         ram_int;
  logic         xstb;

  // machine cycle pacing
  emc_mc_timer emc_mc_timer_inst (
    .clk_i     (CLK_SYS_I),
    .rst_n_i   (RST_N_I),
    .six_clk_i (SIX_CLOCK_MODE_I),
    .sub_o     (t_sub),
    .half_o    (t_half),
    .last_o    (t_last)
  );

  // sequencing, reset pin handling and next pin levels
  always_comb begin
    r_next    = r_reg;
    ext_fetch = r_reg.ext_fetch && !BOOT_LOCKOUT_I;  // [R9] [R10]
    if (SIX_CLOCK_MODE_I) begin
      ale_win   = emc_in_win(t_sub, EMC_ALE_FIRST_SIX, EMC_ALE_LAST_SIX);  // [R13]
      fetch_win = emc_in_win(t_sub, EMC_FETCH_FIRST_SIX, EMC_FETCH_LAST_SIX);
    end else begin
      ale_win   = emc_in_win(t_sub, EMC_ALE_FIRST_STD, EMC_ALE_LAST_STD);  // [R12]
      fetch_win = emc_in_win(t_sub, EMC_FETCH_FIRST_STD, EMC_FETCH_LAST_STD);
    end
    ext_data = r_reg.acc_active && r_reg.acc_ext;
    // expanded RAM claims the low page unless switched off
    ram_int  = !EXPANDED_RAM_OFF_I && (!XREQ_I.wide || XREQ_I.addr[15:8] == EMC_ERAM_PAGE);  // [R18]
    xstb     = ext_data && t_half && (t_sub >= EMC_XSTB_FIRST);
    r_next.xdone      = 1'b0;
    r_next.program_pulse_in_n_pulse = 1'b0;
    r_next.fetch_prev = PROGRAM_FETCH_STROBE_N_I;
    r_next.program_pulse_in_n_prev  = PROGRAM_PULSE_IN_N_I;
    r_next.pins       = EMC_PINS_RST;

    case (r_reg.st)
      EMC_ST_RUN: begin
        // one data access spans one whole machine cycle
        if (t_last) begin
          if (r_reg.acc_active) begin
            r_next.acc_active = 1'b0;
            r_next.xdone      = 1'b1;
          end else if (XREQ_I.valid) begin
            r_next.acc_active = 1'b1;
            r_next.acc_write  = XREQ_I.write;
            r_next.acc_wide   = XREQ_I.wide;
            r_next.acc_hi     = XREQ_I.addr[15:8];
            r_next.acc_ext    = !ram_int;  // [R18]
          end
        end
        // fetch strobe: high when internal or in an external data access, paced pulses otherwise
        r_next.pins.program_fetch_strobe_n = !(ext_fetch && fetch_win && !ext_data);  // [R3] [R4] [R5]
        // latch pulse: dropped in the strobe half of a data access
        r_next.pins.ale = ale_win && !(ext_data && t_half)            // [R11] [R14]
                          && (!LATCH_PULSE_OFF_I || ext_fetch || ext_data);  // [R15]
        r_next.pins.rd_n = !(xstb && !r_reg.acc_write);  // [R2]
        r_next.pins.wr_n = !(xstb && r_reg.acc_write);   // [R1]
        // high address byte: data pointer or program counter
        if (ext_data && r_reg.acc_wide) begin
          r_next.pins.addr_hi    = r_reg.acc_hi;  // [R17]
          r_next.pins.addr_hi_oe = 1'b1;
        end else if (ext_fetch && !ext_data) begin
          r_next.pins.addr_hi    = FETCH_ADDR_HI_I;  // [R17]
          r_next.pins.addr_hi_oe = 1'b1;
        end
        if (DEV_RESET_I) begin
          r_next.st        = EMC_ST_HELD;
          r_next.held_mc   = 5'h00;
          r_next.edge_seen = 1'b0;
        end
      end
      EMC_ST_HELD: begin
        // fetch pin released so a host may drive it
        r_next.pins.fetch_oe   = 1'b0;
        r_next.acc_active      = 1'b0;
        r_next.ext_fetch       = !EXTERNAL_FETCH_STRAP_N_I;  // [R9]
        if (t_last && r_reg.held_mc != EMC_HELD_SAT) begin
          r_next.held_mc = r_reg.held_mc + 5'h01;
        end
        // only once released, so the tail of our own strobe is no host edge
        if (r_reg.fetch_prev && !PROGRAM_FETCH_STROBE_N_I && !r_reg.pins.fetch_oe) begin
          r_next.edge_seen = 1'b1;  // [R6]
        end
        r_next.core_reset = r_reg.held_mc >= RESET_MC;  // [R7]
        if (!DEV_RESET_I) begin
          r_next.core_reset = 1'b0;
          if (r_reg.held_mc >= RESET_MC) begin
            r_next.host_mode = r_reg.edge_seen && (r_reg.held_mc > HOST_ENTRY_MC);  // [R6] [R8]
            r_next.st        = (r_reg.edge_seen && (r_reg.held_mc > HOST_ENTRY_MC)) ? EMC_ST_HOST
                                                                                     : EMC_ST_RUN;
          end else begin
            r_next.st = r_reg.host_mode ? EMC_ST_HOST : EMC_ST_RUN;
          end
        end
      end
      EMC_ST_HOST: begin
        // latch pin turns into the programming pulse input
        r_next.pins.fetch_oe = 1'b0;
        r_next.pins.ale_oe   = 1'b0;
        if (r_reg.program_pulse_in_n_prev && !PROGRAM_PULSE_IN_N_I) begin
          r_next.program_pulse_in_n_pulse = 1'b1;  // [R16]
        end
        if (DEV_RESET_I) begin
          r_next.st        = EMC_ST_HELD;
          r_next.held_mc   = 5'h00;
          r_next.edge_seen = 1'b0;
        end
      end
      default: begin
        r_next.st = EMC_ST_RUN;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      r_reg <= EMC_MAIN_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  // outputs straight from the state register
  assign PINS_O       = r_reg.pins;
  assign XBUSY_O      = r_reg.acc_active;
  assign XDONE_O      = r_reg.xdone;
  assign CORE_RESET_O = r_reg.core_reset;
  assign HOST_MODE_O  = r_reg.host_mode;
  assign PROGRAM_PULSE_IN_N_PULSE_O = r_reg.program_pulse_in_n_pulse;

  // checks on the strobes and the reset sequence
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (!RST_N_I);

  property p_wr_cause;
    $fell(PINS_O.wr_n) |-> r_reg.acc_active && r_reg.acc_ext && r_reg.acc_write && t_half;
  endproperty
  a_wr_cause: assert property (p_wr_cause) else $error("write strobe without external write"); // [R1]

  property p_rd_cause;
    $fell(PINS_O.rd_n) |-> r_reg.acc_active && r_reg.acc_ext && !r_reg.acc_write && t_half;
  endproperty
  a_rd_cause: assert property (p_rd_cause) else $error("read strobe without external read"); // [R2]

  property p_fetch_idle;
    (r_reg.st == EMC_ST_RUN) && !ext_fetch ##1 (r_reg.st == EMC_ST_RUN) && !ext_fetch
      |-> PINS_O.program_fetch_strobe_n;
  endproperty
  a_fetch_idle: assert property (p_fetch_idle) else $error("fetch strobe low during internal fetch"); // [R3]

  property p_fetch_pulse;
    (r_reg.st == EMC_ST_RUN) && ext_fetch && !r_reg.acc_active && t_sub == 3'h0 && !t_half
      && !SIX_CLOCK_MODE_I
      ##1 ((r_reg.st == EMC_ST_RUN) && ext_fetch && !r_reg.acc_active && !SIX_CLOCK_MODE_I)[*5]
      |-> ##[0:2] !PINS_O.program_fetch_strobe_n;
  endproperty
  a_fetch_pulse: assert property (p_fetch_pulse) else $error("no fetch pulse in first half"); // [R4]

  property p_fetch_skip;
    r_reg.acc_active && r_reg.acc_ext |=> PINS_O.program_fetch_strobe_n;
  endproperty
  a_fetch_skip: assert property (p_fetch_skip) else $error("fetch pulse during data access"); // [R5]

  property p_host_entry;
    (r_reg.st == EMC_ST_HELD) && !DEV_RESET_I && r_reg.edge_seen && (r_reg.held_mc > HOST_ENTRY_MC)
      |=> HOST_MODE_O ##1 !PINS_O.ale_oe;
  endproperty
  a_host_entry: assert property (p_host_entry) else $error("host mode not entered"); // [R6]

  property p_core_reset;
    (r_reg.st == EMC_ST_HELD) && DEV_RESET_I && (r_reg.held_mc >= RESET_MC) |=> CORE_RESET_O;
  endproperty
  a_core_reset: assert property (p_core_reset) else $error("held reset not applied"); // [R7]

  property p_normal_exit;
    (r_reg.st == EMC_ST_HELD) && !DEV_RESET_I && !r_reg.edge_seen && (r_reg.held_mc >= RESET_MC)
      |=> !HOST_MODE_O && !CORE_RESET_O && (r_reg.st == EMC_ST_RUN);
  endproperty
  a_normal_exit: assert property (p_normal_exit) else $error("normal mode not entered"); // [R8]

  property p_lockout;
    BOOT_LOCKOUT_I && (r_reg.st == EMC_ST_RUN) && !r_reg.acc_active |=> PINS_O.program_fetch_strobe_n;
  endproperty
  a_lockout: assert property (p_lockout) else $error("external fetch despite lockout"); // [R10]

  property p_ale_drop;
    ext_data && t_half |=> !PINS_O.ale;
  endproperty
  a_ale_drop: assert property (p_ale_drop) else $error("latch pulse in data strobe half"); // [R14]

  property p_ale_off;
    LATCH_PULSE_OFF_I && !ext_fetch && !r_reg.acc_active |=> !PINS_O.ale;
  endproperty
  a_ale_off: assert property (p_ale_off) else $error("latch pulse while switched off"); // [R15]

  property p_program_pulse_in_n_in;
    (r_reg.st == EMC_ST_HOST) && !DEV_RESET_I && r_reg.program_pulse_in_n_prev && !PROGRAM_PULSE_IN_N_I
      |=> PROGRAM_PULSE_IN_N_PULSE_O ##1 !PROGRAM_PULSE_IN_N_PULSE_O;
  endproperty
  a_program_pulse_in_n_in: assert property (p_program_pulse_in_n_in) else $error("programming pulse lost"); // [R16]

  property p_addr_hi;
    ext_data && r_reg.acc_wide && (r_reg.st == EMC_ST_RUN) |=> PINS_O.addr_hi_oe && PINS_O.addr_hi == $past(r_reg.acc_hi);
  endproperty
  a_addr_hi: assert property (p_addr_hi) else $error("high address byte missing"); // [R17]

  property p_eram_quiet;
    r_reg.acc_active && !r_reg.acc_ext |=> PINS_O.rd_n && PINS_O.wr_n;
  endproperty
  a_eram_quiet: assert property (p_eram_quiet) else $error("strobe on expanded RAM access"); // [R18]

  property p_strobe_excl;
    PINS_O.rd_n || PINS_O.wr_n;
  endproperty
  a_strobe_excl: assert property (p_strobe_excl) else $error("read and write strobes together"); // [R1] [R2]

  property p_rd_end;
    $rose(PINS_O.rd_n) |-> !XBUSY_O;
  endproperty
  a_rd_end: assert property (p_rd_end) else $error("read strobe ended inside access"); // [R2]

  property p_wr_end;
    $rose(PINS_O.wr_n) |-> !XBUSY_O;
  endproperty
  a_wr_end: assert property (p_wr_end) else $error("write strobe ended inside access"); // [R1]

  property p_take_edge;
    $rose(XBUSY_O) |-> $past(t_last);
  endproperty
  a_take_edge: assert property (p_take_edge) else $error("access started off cycle boundary"); // [R19]

  property p_done_end;
    $fell(XBUSY_O) && $past(r_reg.st) == EMC_ST_RUN |-> XDONE_O;
  endproperty
  a_done_end: assert property (p_done_end) else $error("access ended without done"); // [R19]

  property p_held_release;
    r_reg.st == EMC_ST_HELD |=> !PINS_O.fetch_oe;
  endproperty
  a_held_release: assert property (p_held_release) else $error("fetch pin driven while reset held"); // [R6]

  property p_held_quiet;
    r_reg.st == EMC_ST_HELD |=> PINS_O.rd_n && PINS_O.wr_n && !PINS_O.ale;
  endproperty
  a_held_quiet: assert property (p_held_quiet) else $error("bus active while reset held"); // [R7]

  property p_host_quiet;
    r_reg.st == EMC_ST_HOST |=> PINS_O.rd_n && PINS_O.wr_n && PINS_O.program_fetch_strobe_n && !PINS_O.addr_hi_oe;
  endproperty
  a_host_quiet: assert property (p_host_quiet) else $error("bus active in host mode"); // [R16]

  property p_ale_width;
    PINS_O.ale ##1 PINS_O.ale |=> !PINS_O.ale;
  endproperty
  a_ale_width: assert property (p_ale_width) else $error("latch pulse too wide"); // [R12]

  property p_ale_six;
    SIX_CLOCK_MODE_I && PINS_O.ale |=> !PINS_O.ale;
  endproperty
  a_ale_six: assert property (p_ale_six) else $error("six-clock latch pulse too wide"); // [R13]

  property p_core_release;
    CORE_RESET_O && !DEV_RESET_I |=> !CORE_RESET_O;
  endproperty
  a_core_release: assert property (p_core_release) else $error("core reset held after pin release"); // [R7]

  property p_hi_idle;
    (r_reg.st == EMC_ST_RUN) && !ext_fetch && !r_reg.acc_active |=> !PINS_O.addr_hi_oe;
  endproperty
  a_hi_idle: assert property (p_hi_idle) else $error("high address byte without access"); // [R17]

  property p_lock_hi;
    BOOT_LOCKOUT_I && (r_reg.st == EMC_ST_RUN) && !r_reg.acc_active |=> !PINS_O.addr_hi_oe;
  endproperty
  a_lock_hi: assert property (p_lock_hi) else $error("fetch address driven despite lockout"); // [R10]

  property p_program_pulse_in_n_host;
    PROGRAM_PULSE_IN_N_PULSE_O |-> $past(r_reg.st) == EMC_ST_HOST;
  endproperty
  a_program_pulse_in_n_host: assert property (p_program_pulse_in_n_host) else $error("programming pulse outside host mode"); // [R16]

  c_ext_write: cover property (r_reg.acc_active && r_reg.acc_ext && r_reg.acc_write ##[1:12] XDONE_O);
  c_ext_read: cover property ($fell(PINS_O.rd_n));
  c_host: cover property ($rose(HOST_MODE_O));
  c_six_ale: cover property (SIX_CLOCK_MODE_I && $rose(PINS_O.ale));
  c_eram: cover property (r_reg.acc_active && !r_reg.acc_ext);

endmodule

/* emc_mem_model.sv */
/*
  far side of the bus: external memory, host and programmer on the shared pins.
  assumes the pins struct of the strobe block and one clock edge per period.
*/
`timescale 1ns/1ps
module emc_mem_model (
  input  wire logic                  clk_i,
  input  wire emc_pkg::emc_pins_type pins_i,
  input  wire logic                  host_drive_i,
  input  wire logic                  host_level_i,
  input  wire logic                  program_pulse_in_n_drive_i,
  input  wire logic                  program_pulse_in_n_level_i,
  output logic                       fetch_pin_o,
  output logic                       latch_pin_o,
  output logic [15:0]                access_count_o
);
  import emc_pkg::*;
  logic        rd_prev = 1'b1;
  logic        wr_prev = 1'b1;
  logic [15:0] count_q = 16'h0000;

  // wire levels: device, else host or programmer, else pull-up
  assign fetch_pin_o = pins_i.fetch_oe ? pins_i.program_fetch_strobe_n : (host_drive_i ? host_level_i : 1'b1);
  assign latch_pin_o = pins_i.ale_oe ? pins_i.ale : (program_pulse_in_n_drive_i ? program_pulse_in_n_level_i : 1'b1);
  assign access_count_o = count_q;

  // one memory access per falling read or write strobe
  always_ff @(posedge clk_i) begin
    rd_prev <= pins_i.rd_n;
    wr_prev <= pins_i.wr_n;
    if ((rd_prev && !pins_i.rd_n) || (wr_prev && !pins_i.wr_n)) begin
      count_q <= count_q + 16'h0001;
    end
  end
endmodule

/* emc_strobe_ctrl_test.sv */
/*
  self-checking bench for the strobe and reset-mode block.
  assumes the memory model resolves the shared fetch and latch pins.
*/
`timescale 1ns/1ps
module emc_strobe_ctrl_test;
  import emc_pkg::*;
  logic         clk_sys = 1'b0, rst_n = 1'b0, dev_reset = 1'b0, strap_n = 1'b1, lockout = 1'b0;
  logic         six_clk = 1'b0, ale_off = 1'b0, eram_off = 1'b1, host_drive = 1'b0, host_level = 1'b1;
  logic         program_pulse_in_n_drive = 1'b0, program_pulse_in_n_level = 1'b1;
  logic [7:0]   fetch_hi = 8'h5a;
  emc_xreq_type xreq = '0;
  emc_pins_type pins;
  logic         fetch_pin, latch_pin, xbusy, xdone, core_reset, host_mode, program_pulse_in_n_pulse;
  logic [15:0]  acc_count;
  logic [7:0]   hi_seen;
  logic         hi_oe_seen;
  int           err_count = 0, check_count = 0;
  int           ale_rises, fetch_falls, rd_low, wr_low, program_pulse_in_n_cnt, rst_seen, done_cnt, hold_rst;

  emc_strobe_ctrl emc_strobe_ctrl_inst (.CLK_SYS_I(clk_sys), .RST_N_I(rst_n), .DEV_RESET_I(dev_reset),
    .EXTERNAL_FETCH_STRAP_N_I(strap_n), .BOOT_LOCKOUT_I(lockout), .SIX_CLOCK_MODE_I(six_clk),
    .LATCH_PULSE_OFF_I(ale_off), .EXPANDED_RAM_OFF_I(eram_off), .FETCH_ADDR_HI_I(fetch_hi), .XREQ_I(xreq),
    .PROGRAM_FETCH_STROBE_N_I(fetch_pin), .PROGRAM_PULSE_IN_N_I(latch_pin), .PINS_O(pins), .XBUSY_O(xbusy),
    .XDONE_O(xdone), .CORE_RESET_O(core_reset), .HOST_MODE_O(host_mode), .PROGRAM_PULSE_IN_N_PULSE_O(program_pulse_in_n_pulse));
  emc_mem_model emc_mem_model_inst (.clk_i(clk_sys), .pins_i(pins), .host_drive_i(host_drive),
    .host_level_i(host_level), .program_pulse_in_n_drive_i(program_pulse_in_n_drive), .program_pulse_in_n_level_i(program_pulse_in_n_level),
    .fetch_pin_o(fetch_pin), .latch_pin_o(latch_pin), .access_count_o(acc_count));

  // 10 MHz clock
  always #50 clk_sys = ~clk_sys;

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // count pin events over n settled samples
  task automatic observe(input int n);
    logic pa, pf;
    ale_rises = 0; fetch_falls = 0; rd_low = 0; wr_low = 0; program_pulse_in_n_cnt = 0; rst_seen = 0; done_cnt = 0;
    pa = pins.ale;
    pf = pins.program_fetch_strobe_n;
    repeat (n) begin
      @(negedge clk_sys);
      if (pins.ale && !pa) ale_rises++;
      if (!pins.program_fetch_strobe_n && pf) fetch_falls++;
      if (!pins.rd_n) rd_low++;
      if (!pins.wr_n) wr_low++;
      if (program_pulse_in_n_pulse) program_pulse_in_n_cnt++;
      if (core_reset) rst_seen++;
      if (xdone) done_cnt++;
      if (!pins.rd_n || !pins.wr_n || !pins.program_fetch_strobe_n) begin
        hi_seen = pins.addr_hi;
        hi_oe_seen = pins.addr_hi_oe;
      end
      pa = pins.ale;
      pf = pins.program_fetch_strobe_n;
    end
  endtask

  // hold the reset pin mc machine cycles, optionally with a host fall on the fetch pin
  task automatic hold_reset(input int mc, input logic fall);
    int seen;
    @(posedge clk_sys);
    dev_reset <= 1'b1;
    observe(24);
    seen = rst_seen;
    check("fetch pin released", pins.fetch_oe, 1'b0);
    if (fall) begin
      @(posedge clk_sys);
      host_drive <= 1'b1;
      @(posedge clk_sys);
      host_level <= 1'b0;
    end
    observe(mc * 12 - 27);
    hold_rst = seen + rst_seen;
    @(posedge clk_sys);
    dev_reset <= 1'b0;
    host_drive <= 1'b0;
    host_level <= 1'b1;
    observe(3);
  endtask

  task automatic t_free_running;
    observe(24);
    check("fetch falls internal", fetch_falls, 0);
    check("ale rises std", ale_rises, 4);
    @(posedge clk_sys);
    ale_off <= 1'b1;
    observe(6);
    observe(24);
    check("ale rises off", ale_rises, 0);
    @(posedge clk_sys);
    ale_off <= 1'b0;
    six_clk <= 1'b1;
    observe(12);
    observe(24);
    check("ale rises six", ale_rises, 8);
    @(posedge clk_sys);
    six_clk <= 1'b0;
    observe(12);
  endtask

  task automatic t_short_reset;
    @(posedge clk_sys);
    dev_reset <= 1'b1;
    observe(6);
    @(posedge clk_sys);
    dev_reset <= 1'b0;
    observe(14);
    check("short reset ignored", rst_seen, 0);
  endtask

  task automatic t_ext_fetch;
    @(posedge clk_sys);
    strap_n <= 1'b0;
    hold_reset(4, 1'b0);
    check("core reset on hold", hold_rst > 0, 1);
    check("core reset released", core_reset, 1'b0);
    check("normal mode", host_mode, 1'b0);
    observe(24);
    check("fetch falls external", fetch_falls, 4);
    check("ale rises external", ale_rises, 4);
    check("fetch high byte", {hi_oe_seen, hi_seen}, {1'b1, fetch_hi});
    @(posedge clk_sys);
    lockout <= 1'b1;
    observe(12);
    observe(24);
    check("fetch falls lockout", fetch_falls, 0);
    @(posedge clk_sys);
    lockout <= 1'b0;
    observe(12);
  endtask

  // one data access; strobes expected unless the expanded ram owns it
  task automatic xfer(input logic wr, input logic wide, input logic [15:0] addr, input logic strobe);
    int n;
    logic [15:0] acc0;
    acc0 = acc_count;
    n = 0;
    @(posedge clk_sys);
    xreq <= '{1'b1, wr, wide, addr};
    while (!xbusy && n < 20) begin
      @(negedge clk_sys);
      n++;
    end
    observe(12);
    @(posedge clk_sys);
    xreq.valid <= 1'b0;
    check("access done", done_cnt, 1);
    // expanded ram access keeps both latch and fetch pulses of the cycle
    check("ale in access", ale_rises, strobe ? 1 : 2);
    check("fetch in access", fetch_falls, strobe ? 0 : 2);
    check("write strobe", wr_low, (strobe && wr) ? 32'(EMC_HALF_STD - 1) : 0);
    check("read strobe", rd_low, (strobe && !wr) ? 32'(EMC_HALF_STD - 1) : 0);
    check("memory accesses", acc_count - acc0, {15'h0000, strobe});
    if (strobe && wide) check("data high byte", {hi_oe_seen, hi_seen}, {1'b1, addr[15:8]});
    observe(12);
  endtask

  task automatic t_host;
    hold_reset(9, 1'b1);
    check("short host hold", host_mode, 1'b0);
    hold_reset(13, 1'b1);
    check("host mode", host_mode, 1'b1);
    check("latch pin released", pins.ale_oe, 1'b0);
    @(posedge clk_sys);
    program_pulse_in_n_drive <= 1'b1;
    program_pulse_in_n_level <= 1'b0;
    observe(4);
    check("program pulse", program_pulse_in_n_cnt, 1);
    @(posedge clk_sys);
    program_pulse_in_n_drive <= 1'b0;
  endtask

  // main sequence
  initial begin
    repeat (9) @(posedge clk_sys);
    @(negedge clk_sys);
    check("reset pins", pins, EMC_PINS_RST);
    check("reset core", {core_reset, host_mode, xbusy}, 3'h0);
    @(posedge clk_sys);
    rst_n <= 1'b1;
    t_free_running();
    t_short_reset();
    t_ext_fetch();
    xfer(1'b1, 1'b1, 16'h3c21, 1'b1);
    xfer(1'b0, 1'b0, 16'h0047, 1'b1);
    @(posedge clk_sys);
    eram_off <= 1'b0;
    xfer(1'b1, 1'b1, 16'h00a0, 1'b0);
    xfer(1'b0, 1'b0, 16'h0012, 1'b0);
    xfer(1'b0, 1'b1, 16'h0100, 1'b1);
    t_host();
    report_and_stop();
  end

  // watchdog
  initial begin
    repeat (6000) @(posedge clk_sys);
    err_count++;
    report_and_stop();
  end
endmodule
